// [shared/tbtc_map.svh]
`ifndef TBTC_MAP_SVH
`define TBTC_MAP_SVH
// ************************************************************
// register indices and byte addresses
// ************************************************************
`define TBTC_IDX_TENBT 6'h1A
`define TBTC_IDX_EXT 6'h1B
`define TBTC_IDX_IRQ_STAT 6'h20
`define TBTC_IDX_IRQ_CLR 6'h21
`define TBTC_IDX_IRQ_EN 6'h22
`define TBTC_ADDR_TENBT ({`TBTC_IDX_TENBT, 2'b00})
`define TBTC_ADDR_EXT ({`TBTC_IDX_EXT, 2'b00})
`define TBTC_ADDR_IRQ_STAT ({`TBTC_IDX_IRQ_STAT, 2'b00})
`define TBTC_ADDR_IRQ_CLR ({`TBTC_IDX_IRQ_CLR, 2'b00})
`define TBTC_ADDR_IRQ_EN ({`TBTC_IDX_IRQ_EN, 2'b00})
// ************************************************************
// field positions
// ************************************************************
`define TBTC_BIT_LP_OFF 7
`define TBTC_BIT_FORCE 6
`define TBTC_BIT_POL 4
`define TBTC_BIT_HB_DIS 1
`define TBTC_BIT_JAB_DIS 0
`define TBTC_BIT_CONT 5
`define TBTC_BIT_PAT_ON 4
`define TBTC_BIT_GAP 2
`define TBTC_LSB_TALLY 8
`define TBTC_BIT_EVT_POL 0
`define TBTC_BIT_EVT_SAT 1
`define TBTC_BIT_EVT_ERR 2
// ************************************************************
// reset values and masks
// ************************************************************
`define TBTC_RST_TENBT 8'h04
`define TBTC_RST_EXT 8'h00
`define TBTC_WMASK_TENBT 8'hEF
`define TBTC_EVT_W 3
// ************************************************************
// timing
// ************************************************************
`define TBTC_CLK_MHZ 200
`define TBTC_GAP_LONG_US 15
`define TBTC_GAP_SHORT_US 10
`define TBTC_GAP_LONG_CYC (`TBTC_GAP_LONG_US * `TBTC_CLK_MHZ)
`define TBTC_GAP_SHORT_CYC (`TBTC_GAP_SHORT_US * `TBTC_CLK_MHZ)
`endif

// [shared/tbtc_pkg.sv]
package tbtc_pkg;
	// low byte of the twisted-pair control register
	typedef struct packed {
		logic link_pulse_off;
		logic force_link;
		logic rsvd5;
		logic polarity;
		logic rsvd3;
		logic rsvd2;
		logic heartbeat_off;
		logic jabber_off;
	} tbtc_tenbt_s;
	// low byte of the extension register
	typedef struct packed {
		logic [1:0] rsvd76;
		logic selftest_continuous;
		logic ten_meg_pattern_on;
		logic rsvd3;
		logic test_sequence_gap;
		logic [1:0] test_pattern_select;
	} tbtc_ext_s;
	typedef enum logic [1:0] {
		TBTC_PAT_EOP0 = 2'h0,
		TBTC_PAT_EOP1 = 2'h1,
		TBTC_PAT_NLP = 2'h2,
		TBTC_PAT_MAN1 = 2'h3
	} tbtc_pat_e;
	typedef enum logic [2:0] {
		TBTC_GT_IDLE = 3'h1,
		TBTC_GT_GAP = 3'h2,
		TBTC_GT_SEQ = 3'h4
	} tbtc_gt_state_e;
endpackage

// [rtl/tbtc_err_tally.sv]
`timescale 1ns/1ps
// saturating error counter for packet self-test
module tbtc_err_tally #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk_i, // core clock
	input wire logic resetn_i, // sync reset, low
	input wire logic restart_i, // self-test started again
	input wire logic active_i, // self-test running
	input wire logic nibble_err_i, // errored nibble seen
	output logic [WIDTH-1:0] tally_o, // current count
	output logic sat_o // pulse on reaching max
);
	logic [WIDTH-1:0] next_tally;
	logic next_sat;

	// restart beats a same-cycle error so a new run starts clean
	always_comb
	begin
		next_tally = tally_o;
		next_sat = 1'b0;
		if (restart_i)
			next_tally = '0; // RULE8
		else if (active_i && nibble_err_i && (tally_o != {WIDTH{1'b1}})) // RULE9
		begin
			next_tally = tally_o + {{(WIDTH-1){1'b0}}, 1'b1}; // RULE7
			next_sat = (tally_o == {{(WIDTH-1){1'b1}}, 1'b0});
		end
	end

	// registers only
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			tally_o <= '0;
			sat_o <= 1'b0;
		end
		else
		begin
			tally_o <= next_tally;
			sat_o <= next_sat;
		end
	end
endmodule

// [rtl/tbtc_gap_timer.sv]
`timescale 1ns/1ps
`include "tbtc_map.svh"
// paces cable test sequences with a long or short idle gap
module tbtc_gap_timer #(
	parameter int CNT_W = 12
) (
	input wire logic sys_clk_i, // core clock
	input wire logic resetn_i, // sync reset, low
	input wire logic enable_i, // pattern generation on
	input wire logic long_gap_i, // 1 = long gap
	input wire logic no_gap_i, // constant pattern, no gap
	input wire logic seq_done_i, // sequence finished
	output logic seq_start_o, // pulse: send a sequence
	output logic in_gap_o // gap running
);
	localparam logic [CNT_W-1:0] LONG_CYC = CNT_W'(`TBTC_GAP_LONG_CYC);
	localparam logic [CNT_W-1:0] SHORT_CYC = CNT_W'(`TBTC_GAP_SHORT_CYC);
	tbtc_pkg::tbtc_gt_state_e state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic next_start;

	// gap length is latched at gap entry; a change lands on the next gap
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_start = 1'b0;
		case (state)
			tbtc_pkg::TBTC_GT_IDLE:
			begin
				if (enable_i)
				begin
					next_state = tbtc_pkg::TBTC_GT_GAP;
					next_cnt = long_gap_i ? LONG_CYC : SHORT_CYC; // RULE15
				end
			end
			tbtc_pkg::TBTC_GT_GAP:
			begin
				if (cnt > {{(CNT_W-1){1'b0}}, 1'b1})
					next_cnt = cnt - {{(CNT_W-1){1'b0}}, 1'b1};
				else
				begin
					next_state = tbtc_pkg::TBTC_GT_SEQ;
					next_start = 1'b1;
				end
			end
			tbtc_pkg::TBTC_GT_SEQ:
			begin
				if (seq_done_i && !no_gap_i)
				begin
					next_state = tbtc_pkg::TBTC_GT_GAP;
					next_cnt = long_gap_i ? LONG_CYC : SHORT_CYC; // RULE15
				end
			end
			default:
				next_state = tbtc_pkg::TBTC_GT_IDLE;
		endcase
		if (!enable_i)
		begin
			next_state = tbtc_pkg::TBTC_GT_IDLE;
			next_start = 1'b0;
		end
	end

	// registers only
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			state <= tbtc_pkg::TBTC_GT_IDLE;
			cnt <= '0;
			seq_start_o <= 1'b0;
			in_gap_o <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			seq_start_o <= next_start;
			in_gap_o <= (next_state == tbtc_pkg::TBTC_GT_GAP);
		end
	end
endmodule

// [rtl/tbtc_top.sv]
// Operation
// RULE1: link pulse off bit stops normal link pulses
// RULE2: force bit reports good ten meg link
// RULE3: polarity latches high, clears on this read
// RULE4: heartbeat off bit acts in half-duplex ten
// RULE5: hundred meg or full duplex: heartbeat off
// RULE6: jabber off bit acts in ten meg only
// RULE7: tally counts errored nibbles during self-test
// RULE8: tally clears when self-test restarts
// RULE9: tally saturates at maximum, never wraps
// RULE10: continuous bit sends gapless pseudo-random data
// RULE11: continuous mode works with external self-test controls
// RULE12: software sets jabber off before continuous ten
// RULE13: pattern on bit starts selected test pattern
// RULE14: select picks eop0, eop1, pulses, manchester
// RULE15: gap bit picks fifteen or ten microseconds
// RULE16: software writes reserved bits as documented
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "tbtc_map.svh"
module tbtc_top #(
	parameter int TALLY_W = 8,
	parameter int GAP_CNT_W = 12
) (
	input wire logic sys_clk_i, // 200 MHz core clock
	input wire logic resetn_i, // sync reset, low
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb direction
	input wire logic [7:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error, unmapped
	input wire logic pol_inverted_i, // receiver sees inverted polarity
	input wire logic line_link_ok_i, // ten meg link monitor good
	input wire logic speed_100_i, // running at hundred meg
	input wire logic full_duplex_i, // full duplex configured
	input wire logic selftest_restart_i, // self-test started, pulse
	input wire logic selftest_active_i, // self-test running
	input wire logic nibble_err_i, // errored nibble this cycle
	input wire logic seq_done_i, // test sequence ended
	output logic nlp_enable_o, // send normal link pulses
	output logic link_good_o, // ten meg link reported good
	output logic polarity_mirror_o, // copy for combined status bit 12
	output logic heartbeat_en_o, // heartbeat function on
	output logic jabber_en_o, // jabber function on
	output logic selftest_gapless_o, // self-test without gaps
	output logic pattern_active_o, // cable test pattern on
	output logic [1:0] pattern_kind_o, // selected pattern
	output logic pattern_start_o, // pulse: start a sequence
	output logic pattern_gap_o, // idle gap running
	output logic irq_o // level interrupt
);
	// ************************************************************
	// register state
	// ************************************************************
	tbtc_pkg::tbtc_tenbt_s tenbt, next_tenbt;
	tbtc_pkg::tbtc_ext_s ext, next_ext;
	logic pol_latch, next_pol_latch;
	logic [`TBTC_EVT_W-1:0] irq_stat, next_irq_stat;
	logic [`TBTC_EVT_W-1:0] irq_en, next_irq_en;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic [TALLY_W-1:0] tally;
	logic tally_sat;
	logic err_evt;
	logic seq_start, in_gap;

	// bus phase decode
	logic setup_ph, done_wr, done_rd;
	assign setup_ph = psel_i && !penable_i;
	assign done_wr = psel_i && penable_i && pready_o && pwrite_i;
	assign done_rd = psel_i && penable_i && pready_o && !pwrite_i;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	// ************************************************************
	// apb slave: one wait-free access phase
	// ************************************************************
	// read data is sampled in setup so the output comes from a flop
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		next_pready = setup_ph;
		next_pslverr = 1'b0;
		if (setup_ph)
		begin
			if (hit(paddr_i, `TBTC_ADDR_TENBT))
			begin
				next_prdata[7:0] = tenbt;
				next_prdata[`TBTC_BIT_POL] = pol_latch; // RULE3
			end
			else if (hit(paddr_i, `TBTC_ADDR_EXT))
			begin
				next_prdata[7:0] = ext;
				next_prdata[`TBTC_LSB_TALLY +: TALLY_W] = tally; // RULE7
			end
			else if (hit(paddr_i, `TBTC_ADDR_IRQ_STAT))
				next_prdata[`TBTC_EVT_W-1:0] = irq_stat;
			else if (hit(paddr_i, `TBTC_ADDR_IRQ_EN))
				next_prdata[`TBTC_EVT_W-1:0] = irq_en;
			else if (!hit(paddr_i, `TBTC_ADDR_IRQ_CLR))
				next_pslverr = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			prdata_o <= next_prdata;
			pready_o <= next_pready;
			pslverr_o <= next_pslverr;
		end
	end

	// ************************************************************
	// control registers
	// ************************************************************
	// polarity: a new inversion in the read cycle is kept, set wins
	always_comb
	begin
		next_tenbt = tenbt;
		next_ext = ext;
		next_irq_en = irq_en;
		next_pol_latch = pol_latch;
		if (done_wr && hit(paddr_i, `TBTC_ADDR_TENBT))
			next_tenbt = (pwdata_i[7:0] & `TBTC_WMASK_TENBT); // RULE16
		if (done_wr && hit(paddr_i, `TBTC_ADDR_EXT))
			next_ext = pwdata_i[7:0];
		if (done_wr && hit(paddr_i, `TBTC_ADDR_IRQ_EN))
			next_irq_en = pwdata_i[`TBTC_EVT_W-1:0];
		if (done_rd && hit(paddr_i, `TBTC_ADDR_TENBT))
			next_pol_latch = 1'b0; // RULE3
		if (pol_inverted_i)
			next_pol_latch = 1'b1; // RULE3
		next_tenbt.polarity = 1'b0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			tenbt <= `TBTC_RST_TENBT;
			ext <= `TBTC_RST_EXT;
			irq_en <= '0;
			pol_latch <= 1'b0;
		end
		else
		begin
			tenbt <= next_tenbt;
			ext <= next_ext;
			irq_en <= next_irq_en;
			pol_latch <= next_pol_latch;
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	// write-one-to-clear; a same-cycle event wins over the clear
	assign err_evt = selftest_active_i && nibble_err_i;
	always_comb
	begin
		next_irq_stat = irq_stat;
		if (done_wr && hit(paddr_i, `TBTC_ADDR_IRQ_CLR))
			next_irq_stat = irq_stat & ~pwdata_i[`TBTC_EVT_W-1:0];
		if (pol_inverted_i && !pol_latch)
			next_irq_stat[`TBTC_BIT_EVT_POL] = 1'b1;
		if (tally_sat)
			next_irq_stat[`TBTC_BIT_EVT_SAT] = 1'b1;
		if (err_evt)
			next_irq_stat[`TBTC_BIT_EVT_ERR] = 1'b1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			irq_stat <= '0;
			irq_o <= 1'b0;
		end
		else
		begin
			irq_stat <= next_irq_stat;
			irq_o <= |(next_irq_stat & irq_en);
		end
	end

	// ************************************************************
	// self-test tally and pattern pacing
	// ************************************************************
	tbtc_err_tally #(
		.WIDTH(TALLY_W)
	) u_tally (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.restart_i(selftest_restart_i),
		.active_i(selftest_active_i),
		.nibble_err_i(nibble_err_i),
		.tally_o(tally),
		.sat_o(tally_sat)
	);

	// manchester ones run back to back, the others are paced
	tbtc_gap_timer #(
		.CNT_W(GAP_CNT_W)
	) u_gap (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.enable_i(ext.ten_meg_pattern_on), // RULE13
		.long_gap_i(ext.test_sequence_gap),
		.no_gap_i(ext.test_pattern_select == tbtc_pkg::TBTC_PAT_MAN1), // RULE14
		.seq_done_i(seq_done_i),
		.seq_start_o(seq_start),
		.in_gap_o(in_gap)
	);

	// ************************************************************
	// function outputs
	// ************************************************************
	// jabber stays on at hundred meg; the bit only has effect at ten
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			nlp_enable_o <= 1'b1;
			link_good_o <= 1'b0;
			polarity_mirror_o <= 1'b0;
			heartbeat_en_o <= 1'b0;
			jabber_en_o <= 1'b1;
			selftest_gapless_o <= 1'b0;
			pattern_active_o <= 1'b0;
			pattern_kind_o <= 2'h0;
			pattern_start_o <= 1'b0;
			pattern_gap_o <= 1'b0;
		end
		else
		begin
			nlp_enable_o <= !tenbt.link_pulse_off; // RULE1
			link_good_o <= tenbt.force_link || line_link_ok_i; // RULE2
			polarity_mirror_o <= next_pol_latch; // RULE3
			heartbeat_en_o <= !speed_100_i && !full_duplex_i && !tenbt.heartbeat_off; // RULE4 RULE5
			jabber_en_o <= speed_100_i || !tenbt.jabber_off; // RULE6 RULE12
			selftest_gapless_o <= ext.selftest_continuous && selftest_active_i; // RULE10 RULE11
			pattern_active_o <= ext.ten_meg_pattern_on; // RULE13
			pattern_kind_o <= ext.test_pattern_select; // RULE14
			pattern_start_o <= seq_start;
			pattern_gap_o <= in_gap; // RULE15
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	sequence s_read_tenbt;
		done_rd && hit(paddr_i, `TBTC_ADDR_TENBT);
	endsequence
	sequence s_no_inversion;
		!pol_inverted_i;
	endsequence

	property p_nlp;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		##1 nlp_enable_o == !$past(tenbt.link_pulse_off);
	endproperty
	a_nlp: assert property (p_nlp) else $error("link pulse enable wrong"); // RULE1

	property p_force;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		tenbt.force_link |=> link_good_o;
	endproperty
	a_force: assert property (p_force) else $error("forced link not good"); // RULE2

	property p_pol_clear;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		s_read_tenbt and s_no_inversion |=> !pol_latch && !polarity_mirror_o;
	endproperty
	a_pol_clear: assert property (p_pol_clear) else $error("polarity not cleared"); // RULE3

	property p_pol_set;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		pol_inverted_i |=> pol_latch && polarity_mirror_o;
	endproperty
	a_pol_set: assert property (p_pol_set) else $error("polarity not latched"); // RULE3

	property p_hb;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(speed_100_i || full_duplex_i) |=> !heartbeat_en_o;
	endproperty
	a_hb: assert property (p_hb) else $error("heartbeat on at 100 or full duplex"); // RULE5

	property p_hb_dis;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(tenbt.heartbeat_off && $stable(tenbt.heartbeat_off)) |=> !heartbeat_en_o;
	endproperty
	a_hb_dis: assert property (p_hb_dis) else $error("heartbeat not disabled"); // RULE4

	property p_jab;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(!speed_100_i && tenbt.jabber_off) |=> !jabber_en_o;
	endproperty
	a_jab: assert property (p_jab) else $error("jabber not disabled"); // RULE6

	property p_restart;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		selftest_restart_i |=> tally == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("tally not cleared"); // RULE8

	property p_count;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(err_evt && !selftest_restart_i && tally != {TALLY_W{1'b1}})
			|=> tally == $past(tally) + 1'b1;
	endproperty
	a_count: assert property (p_count) else $error("tally missed an error"); // RULE7

	property p_sat;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(tally == {TALLY_W{1'b1}} && !selftest_restart_i) |=> tally == {TALLY_W{1'b1}};
	endproperty
	a_sat: assert property (p_sat) else $error("tally wrapped"); // RULE9

	property p_cont;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		selftest_gapless_o |-> $past(ext.selftest_continuous) && $past(selftest_active_i);
	endproperty
	a_cont: assert property (p_cont) else $error("gapless without self-test"); // RULE11
endmodule

// [test/tbtc_tb_top.sv]
`timescale 1ns/1ps
`include "tbtc_map.svh"
module tbtc_tb_top;
	logic sys_clk_i = 1'h0;
	logic resetn_i = 1'h0;
	logic psel_i = 1'h0;
	logic penable_i = 1'h0;
	logic pwrite_i = 1'h0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o;
	logic pol_inverted_i = 1'h0;
	logic line_link_ok_i = 1'h0;
	logic speed_100_i = 1'h0;
	logic full_duplex_i = 1'h0;
	logic selftest_restart_i = 1'h0;
	logic selftest_active_i = 1'h0;
	logic nibble_err_i = 1'h0;
	logic seq_done_i = 1'h0;
	logic nlp_enable_o, link_good_o, polarity_mirror_o, heartbeat_en_o, jabber_en_o;
	logic selftest_gapless_o, pattern_active_o, pattern_start_o, pattern_gap_o, irq_o;
	logic [1:0] pattern_kind_o;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int total_checks = 0;
	int n;
	// strobe selectors for pulse
	localparam int STB_POL = 0;
	localparam int STB_RESTART = 1;
	localparam int STB_NIBBLE = 2;
	localparam int STB_DONE = 3;

	tbtc_top dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.pol_inverted_i(pol_inverted_i), .line_link_ok_i(line_link_ok_i),
		.speed_100_i(speed_100_i), .full_duplex_i(full_duplex_i),
		.selftest_restart_i(selftest_restart_i), .selftest_active_i(selftest_active_i),
		.nibble_err_i(nibble_err_i), .seq_done_i(seq_done_i), .nlp_enable_o(nlp_enable_o),
		.link_good_o(link_good_o), .polarity_mirror_o(polarity_mirror_o),
		.heartbeat_en_o(heartbeat_en_o), .jabber_en_o(jabber_en_o),
		.selftest_gapless_o(selftest_gapless_o), .pattern_active_o(pattern_active_o),
		.pattern_kind_o(pattern_kind_o), .pattern_start_o(pattern_start_o),
		.pattern_gap_o(pattern_gap_o), .irq_o(irq_o));

	// free running 200 MHz clock
	always #2.5 sys_clk_i = ~sys_clk_i;

	// ************************************************************
	// helper tasks
	// ************************************************************
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			fail_count++;
		end
	endtask

	task automatic check1(input string what, input logic seen, input logic exp);
		check(what, {31'h0, seen}, {31'h0, exp});
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk_i);
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int i;
		@(posedge sys_clk_i);
		psel_i <= 1'h1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'h1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge sys_clk_i);
			if (pready_o === 1'h1)
				break;
		end
		if (i == 20)
		begin
			$display("Error apb wait expected ready seen timeout");
			fail_count++;
			end_sim();
		end
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d, rd, err);
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0, rd, err);
		check(what, rd, exp);
	endtask

	// drives module-level strobes directly, since a ref argument cannot take a nonblocking write
	task automatic strobe(input int which, input logic v);
		case (which)
			STB_POL: pol_inverted_i <= v;
			STB_RESTART: selftest_restart_i <= v;
			STB_NIBBLE: nibble_err_i <= v;
			default: seq_done_i <= v;
		endcase
	endtask

	// hold a strobe input high for k cycles
	task automatic pulse(input int which, input int k);
		@(posedge sys_clk_i);
		strobe(which, 1'h1);
		tick(k);
		strobe(which, 1'h0);
	endtask

	// counts cycles to the next sequence start; bound covers the long gap
	task automatic gap_len(output int c);
		c = 0;
		while (pattern_start_o !== 1'h1 && c < 4000)
		begin
			@(posedge sys_clk_i);
			c++;
		end
		if (c >= 4000)
		begin
			$display("Error gap wait expected start seen timeout");
			fail_count++;
			end_sim();
		end
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		tick(5);
		resetn_i <= 1'h1;
		rdchk("tenbt reset", `TBTC_ADDR_TENBT, 32'h04);
		rdchk("ext reset", `TBTC_ADDR_EXT, 32'h0);
		check1("nlp reset", nlp_enable_o, 1'h1);
		check1("hb reset", heartbeat_en_o, 1'h1);
		check1("jab reset", jabber_en_o, 1'h1);
		// polarity bit is read-only, so the written one must not show
		wr(`TBTC_ADDR_TENBT, 32'hD7);
		tick(2);
		rdchk("tenbt rw", `TBTC_ADDR_TENBT, 32'hC7);
		check1("nlp off", nlp_enable_o, 1'h0);
		check1("link forced", link_good_o, 1'h1);
		check1("hb off", heartbeat_en_o, 1'h0);
		check1("jab off", jabber_en_o, 1'h0);
		speed_100_i <= 1'h1;
		tick(2);
		check1("jab at 100", jabber_en_o, 1'h1);
		wr(`TBTC_ADDR_TENBT, 32'h04);
		tick(2);
		check1("hb at 100", heartbeat_en_o, 1'h0);
		speed_100_i <= 1'h0;
		full_duplex_i <= 1'h1;
		tick(2);
		check1("hb fdx", heartbeat_en_o, 1'h0);
		full_duplex_i <= 1'h0;
		tick(2);
		check1("hb half", heartbeat_en_o, 1'h1);
		check1("link normal", link_good_o, 1'h0);
		line_link_ok_i <= 1'h1;
		tick(2);
		check1("link line", link_good_o, 1'h1);
		check1("nlp on", nlp_enable_o, 1'h1);
		// polarity latch, its mirror and the interrupt path
		wr(`TBTC_ADDR_IRQ_EN, 32'h1);
		pulse(STB_POL, 3);
		tick(3);
		check1("pol mirror", polarity_mirror_o, 1'h1);
		check1("irq raised", irq_o, 1'h1);
		rdchk("stat pol", `TBTC_ADDR_IRQ_STAT, 32'h1);
		tick(2);
		check1("mirror kept", polarity_mirror_o, 1'h1);
		rdchk("pol latched", `TBTC_ADDR_TENBT, 32'h14);
		tick(2);
		check1("mirror clr", polarity_mirror_o, 1'h0);
		rdchk("pol cleared", `TBTC_ADDR_TENBT, 32'h04);
		wr(`TBTC_ADDR_IRQ_EN, 32'h0);
		tick(2);
		check1("irq masked", irq_o, 1'h0);
		wr(`TBTC_ADDR_IRQ_EN, 32'h1);
		tick(2);
		check1("irq unmasked", irq_o, 1'h1);
		wr(`TBTC_ADDR_IRQ_CLR, 32'h1);
		tick(2);
		check1("irq cleared", irq_o, 1'h0);
		rdchk("stat clr", `TBTC_ADDR_IRQ_STAT, 32'h0);
		rdchk("clr reads 0", `TBTC_ADDR_IRQ_CLR, 32'h0);
		apb(1'h0, 8'hFC, 32'h0, rd, err);
		check("unmapped data", rd, 32'h0);
		check1("unmapped err", err, 1'h1);
		// error tally: count, ignore when idle, restart, saturate
		selftest_active_i <= 1'h1;
		pulse(STB_RESTART, 1);
		pulse(STB_NIBBLE, 5);
		tick(2);
		rdchk("tally 5", `TBTC_ADDR_EXT, 32'h0500);
		selftest_active_i <= 1'h0;
		pulse(STB_NIBBLE, 3);
		tick(2);
		rdchk("tally idle", `TBTC_ADDR_EXT, 32'h0500);
		selftest_active_i <= 1'h1;
		pulse(STB_RESTART, 1);
		tick(2);
		rdchk("tally restart", `TBTC_ADDR_EXT, 32'h0);
		pulse(STB_NIBBLE, 300);
		tick(2);
		rdchk("tally sat", `TBTC_ADDR_EXT, 32'hFF00);
		rdchk("stat sat", `TBTC_ADDR_IRQ_STAT, 32'h6);
		pulse(STB_RESTART, 1);
		// continuous mode needs jabber off first at ten meg
		wr(`TBTC_ADDR_TENBT, 32'h05);
		wr(`TBTC_ADDR_EXT, 32'h20);
		tick(2);
		check1("gapless", selftest_gapless_o, 1'h1);
		selftest_active_i <= 1'h0;
		tick(2);
		check1("gapless idle", selftest_gapless_o, 1'h0);
		// every pattern select value reaches the output
		for (int k = 0; k < 4; k++)
		begin
			wr(`TBTC_ADDR_EXT, 32'h10 | k);
			tick(2);
			check("pattern kind", {30'h0, pattern_kind_o}, k);
			check1("pattern on", pattern_active_o, 1'h1);
		end
		wr(`TBTC_ADDR_EXT, 32'h0);
		tick(2);
		wr(`TBTC_ADDR_EXT, 32'h10);
		// gap flag passes the timer flop and the output flop: three edges
		tick(3);
		check1("gap running", pattern_gap_o, 1'h1);
		gap_len(n);
		check1("short gap", n >= 1993 && n <= 2003, 1'h1);
		wr(`TBTC_ADDR_EXT, 32'h14);
		pulse(STB_DONE, 1);
		gap_len(n);
		check1("long gap", n >= 2993 && n <= 3003, 1'h1);
		wr(`TBTC_ADDR_EXT, 32'h0);
		wr(`TBTC_ADDR_EXT, 32'h13);
		gap_len(n);
		pulse(STB_DONE, 1);
		tick(10);
		check1("manchester nogap", pattern_gap_o, 1'h0);
		wr(`TBTC_ADDR_EXT, 32'h0);
		tick(2);
		check1("pattern off", pattern_active_o, 1'h0);
		check1("gap off", pattern_gap_o, 1'h0);
		end_sim();
	end
endmodule
